// ==== logic/ppm_port_pin_mux.v ====
// Top of the port pin mux group: registers, port-7 muxing, port 8 and port B.
`include "ppm_defines.vh"

module ppm_port_pin_mux (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Register port
    input wire [`PPM_ADDR_W-1:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    // Peripheral selection settings
    input wire [3:0] timerOutSelect,
    input wire rxEnable,
    input wire clockSourceBit1,
    input wire clockSourceBit0,
    input wire clockedMode,
    input wire [7:0] analogChannelMask,
    // Peripheral signals
    input wire timerCompareOut,
    output wire timerCountIn,
    output wire timerResetIn,
    input wire serialTxData,
    output wire serialRxData,
    input wire serialClockOut,
    output wire serialClockIn,
    // Port 7 pads
    input wire [7:0] port7PinIn,
    output wire [7:0] port7PinOut,
    output wire [7:0] port7PinOe,
    // Port 8 pads
    input wire [7:0] port8PinIn,
    output wire [7:0] port8PinOut,
    output wire [7:0] port8PinOe,
    // Port B pads
    input wire [7:0] analogPortPins,
    output wire [7:0] analogPortOut,
    output wire [7:0] analogPortOe
);

    // ======================================================================
    // Register storage.
    reg [7:0] port7Dir_reg;
    reg [7:0] port7Data_reg;
    reg [7:0] funcSel_reg;
    reg [7:0] port7Dir_next;
    reg [7:0] port7Data_next;
    reg [7:0] funcSel_next;
    reg [7:0] regRdata_next;
    wire [2:0] p8Rd;
    wire writeHit7Dir;
    wire writeHit7Data;
    wire writeHit8Dir;
    wire writeHit8Data;
    wire writeHitFunc;
    wire txSelect;
    wire [7:0] p7ReadBack;
    wire [7:0] p8ReadBack;
    wire [7:0] pbReadBack;
    reg [7:0] readMux;

    function hitAddr;
        input [`PPM_ADDR_W-1:0] a;
        input [`PPM_ADDR_W-1:0] ofs;
        begin
            hitAddr = (a == ofs);
        end
    endfunction

    // A pin read shows the stored bit while it drives and the live level while it listens.
    function readSel;
        input dir;
        input stored;
        input pin;
        begin
            readSel = dir ? stored : pin;
        end
    endfunction

    // ======================================================================
    // Write decode.
    assign writeHit7Dir = regWr && hitAddr(regAddr, `PPM_OFS_P7_DIR);
    assign writeHit7Data = regWr && hitAddr(regAddr, `PPM_OFS_P7_DATA);
    assign writeHit8Dir = regWr && hitAddr(regAddr, `PPM_OFS_P8_DIR);
    assign writeHit8Data = regWr && hitAddr(regAddr, `PPM_OFS_P8_DATA);
    assign writeHitFunc = regWr && hitAddr(regAddr, `PPM_OFS_FUNC_SEL);
    assign txSelect = funcSel_reg[`PPM_FUNC_TX_SEL];

    // Reserved port-7 positions and the unused select bits never take a write.
    always @* begin
        port7Dir_next = port7Dir_reg;
        port7Data_next = port7Data_reg;
        funcSel_next = funcSel_reg;
        if (writeHit7Dir) begin
            port7Dir_next = regWdata & `PPM_P7_MASK;
        end
        if (writeHit7Data) begin
            port7Data_next = regWdata & `PPM_P7_MASK;
        end
        if (writeHitFunc) begin
            funcSel_next = {7'h00, regWdata[`PPM_FUNC_TX_SEL]};
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port7Dir_reg <= `PPM_DIR_RST;
            port7Data_reg <= `PPM_DATA_RST;
            funcSel_reg <= `PPM_FUNC_RST;
        end else begin
            port7Dir_reg <= port7Dir_next;
            port7Data_reg <= port7Data_next;
            funcSel_reg <= funcSel_next;
        end
    end

    // ======================================================================
    // Port 7 pin ownership.
    wire cmpOwn;
    wire sckOwn;
    wire sckDrive;

    // The timer keeps its pin even when the direction bit asks for an input.
    // timer output select
    assign cmpOwn = (timerOutSelect != `PPM_TOS_OFF);
    assign sckOwn = clockSourceBit1 | clockSourceBit0 | clockedMode;
    // An external clock source turns the pin around so two drivers never meet.
    assign sckDrive = ~clockSourceBit1;

    ppm_port7_pin uCmp (
        .periphOwn(cmpOwn),
        .periphDrive(1'b1),
        .periphOut(timerCompareOut),
        .gpioDir(port7Dir_reg[`PPM_P7_CMP_OUT]),
        .gpioData(port7Data_reg[`PPM_P7_CMP_OUT]),
        .padOut(port7PinOut[`PPM_P7_CMP_OUT]),
        .padOe(port7PinOe[`PPM_P7_CMP_OUT])
    );

    ppm_port7_pin uCnt (
        .periphOwn(1'b0),
        .periphDrive(1'b0),
        .periphOut(1'b0),
        .gpioDir(port7Dir_reg[`PPM_P7_CNT_IN]),
        .gpioData(port7Data_reg[`PPM_P7_CNT_IN]),
        .padOut(port7PinOut[`PPM_P7_CNT_IN]),
        .padOe(port7PinOe[`PPM_P7_CNT_IN])
    );

    ppm_port7_pin uRst (
        .periphOwn(1'b0),
        .periphDrive(1'b0),
        .periphOut(1'b0),
        .gpioDir(port7Dir_reg[`PPM_P7_RST_IN]),
        .gpioData(port7Data_reg[`PPM_P7_RST_IN]),
        .padOut(port7PinOut[`PPM_P7_RST_IN]),
        .padOe(port7PinOe[`PPM_P7_RST_IN])
    );

    ppm_port7_pin uTx (
        .periphOwn(txSelect),
        .periphDrive(1'b1),
        .periphOut(serialTxData),
        .gpioDir(port7Dir_reg[`PPM_P7_TX]),
        .gpioData(port7Data_reg[`PPM_P7_TX]),
        .padOut(port7PinOut[`PPM_P7_TX]),
        .padOe(port7PinOe[`PPM_P7_TX])
    );

    ppm_port7_pin uRx (
        .periphOwn(rxEnable),
        .periphDrive(1'b0),
        .periphOut(1'b0),
        .gpioDir(port7Dir_reg[`PPM_P7_RX]),
        .gpioData(port7Data_reg[`PPM_P7_RX]),
        .padOut(port7PinOut[`PPM_P7_RX]),
        .padOe(port7PinOe[`PPM_P7_RX])
    );

    ppm_port7_pin uSck (
        .periphOwn(sckOwn),
        .periphDrive(sckDrive),
        .periphOut(serialClockOut),
        .gpioDir(port7Dir_reg[`PPM_P7_SCK]),
        .gpioData(port7Data_reg[`PPM_P7_SCK]),
        .padOut(port7PinOut[`PPM_P7_SCK]),
        .padOe(port7PinOe[`PPM_P7_SCK])
    );

    // Reserved positions 7 and 3 never drive.
    assign port7PinOut[7] = 1'b0;
    assign port7PinOe[7] = 1'b0;
    assign port7PinOut[3] = 1'b0;
    assign port7PinOe[3] = 1'b0;

    // ======================================================================
    // Peripheral input feeds.
    // timer inputs always fed
    assign timerCountIn = port7PinIn[`PPM_P7_CNT_IN];
    assign timerResetIn = port7PinIn[`PPM_P7_RST_IN];
    assign serialRxData = port7PinIn[`PPM_P7_RX];
    // Gated so the clock input does not see the pad echo of its own output.
    assign serialClockIn = clockSourceBit1 & port7PinIn[`PPM_P7_SCK];

    // ======================================================================
    // Port 7 read-back.
    // Unclaimed port-7 pins read back like port 8; reserved bits read 1.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gP7Read
            if (g == 7 || g == 3) begin : gRsvd
                assign p7ReadBack[g] = 1'b1;
            end else begin : gPin
                assign p7ReadBack[g] = readSel(port7Dir_reg[g], port7Data_reg[g], port7PinIn[g]);
            end
        end
    endgenerate

    // ======================================================================
    // Port 8.
    generate
        for (g = 0; g < 3; g = g + 1) begin : gP8
            ppm_port8_pin uPin (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .dirWe(writeHit8Dir),
                .dataWe(writeHit8Data),
                .wrBit(regWdata[g + 5]),
                .padIn(port8PinIn[g + 5]),
                .padOut(port8PinOut[g + 5]),
                .padOe(port8PinOe[g + 5]),
                .rdDir(),
                .rdData(p8Rd[g])
            );
        end
    endgenerate

    assign port8PinOut[4:0] = 5'h00;
    assign port8PinOe[4:0] = 5'h00;
    assign p8ReadBack = {p8Rd, 5'h00} | `PPM_P8_RSVD;

    // ======================================================================
    // Port B.
    // analog channels read 0
    assign pbReadBack = analogPortPins & ~analogChannelMask;
    assign analogPortOut = 8'h00;
    assign analogPortOe = 8'h00;

    // ======================================================================
    // Read path. Direction registers are write-only and read as zero.
    always @* begin
        case (regAddr)
            `PPM_OFS_P7_DIR: readMux = 8'h00;
            `PPM_OFS_P8_DIR: readMux = 8'h00;
            `PPM_OFS_P7_DATA: readMux = p7ReadBack;
            `PPM_OFS_P8_DATA: readMux = p8ReadBack;
            `PPM_OFS_PB_DATA: readMux = pbReadBack;
            `PPM_OFS_FUNC_SEL: readMux = funcSel_reg;
            default: readMux = 8'h00;
        endcase
    end

    // Read data stand for one cycle only; idle zeros keep a stale byte from passing as a read.
    always @* begin
        regRdata_next = 8'h00;
        if (regRd) begin
            regRdata_next = readMux;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRdata_next;
        end
    end

endmodule

// ==== logic/ppm_defines.vh ====
// Register map, field positions, reset values and functional notes for the port pin mux group.
// Functional notes
// - Compare-output pin is GPIO only when timer output select is zero; otherwise timer output.
// - Count-input and reset-input pins always feed their levels to the timer.
// - Transmit-select bit 1 drives serial transmit on its pin; 0 gives GPIO.
// - Receive-enable 1 makes its pin serial receive input; 0 gives GPIO.
// - Clock pin input if bit1; output if bit0 or clocked mode; else GPIO.
// - Port-8 direction bits are write-only, reset 0, 1 output and 0 input.
// - Port-8 data bits 7..5 reset 0 and drive output pins.
// - Port-8 data read returns stored value where direction is 1.
// - Port-8 data read returns live pin level where direction is 0.
// - Port-8 data bits 4..0 always read 1 and ignore writes.
// - Port-B data register is read-only and returns pin levels.
// - Port-B bits selected as analog inputs read as 0.
// - Port-7 direction 1 gives output, 0 input, when no peripheral claims pin.
// - Peripheral claims of port-7 pins take precedence over general I/O.
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH

// ==========================================================================
// Register offsets (byte addresses on the plain register port).
`define PPM_ADDR_W 4
`define PPM_OFS_P7_DIR 4'h0
`define PPM_OFS_P7_DATA 4'h1
`define PPM_OFS_P8_DIR 4'h2
`define PPM_OFS_P8_DATA 4'h3
`define PPM_OFS_PB_DATA 4'h4
`define PPM_OFS_FUNC_SEL 4'h5

// ==========================================================================
// Field positions and masks.
`define PPM_P7_MASK 8'h77
`define PPM_P7_CMP_OUT 6
`define PPM_P7_CNT_IN 5
`define PPM_P7_RST_IN 4
`define PPM_P7_TX 2
`define PPM_P7_RX 1
`define PPM_P7_SCK 0
`define PPM_P8_MASK 8'hE0
`define PPM_P8_RSVD 8'h1F
`define PPM_FUNC_TX_SEL 0

// ==========================================================================
// Reset values.
`define PPM_DIR_RST 8'h00
`define PPM_DATA_RST 8'h00
`define PPM_FUNC_RST 8'h00
`define PPM_TOS_OFF 4'h0

`endif

// ==== logic/ppm_port7_pin.v ====
// One shared port-7 pin: chooses between peripheral and general I/O driving.
module ppm_port7_pin (
    // Peripheral claim
    input wire periphOwn,
    input wire periphDrive,
    input wire periphOut,
    // General I/O
    input wire gpioDir,
    input wire gpioData,
    // Pad
    output wire padOut,
    output wire padOe
);

    assign padOe = periphOwn ? periphDrive : gpioDir;
    assign padOut = periphOwn ? periphOut : gpioData;

endmodule

// ==== logic/ppm_port8_pin.v ====
// One port-8 pin: direction and data storage bit with read-back selection.
module ppm_port8_pin (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Register writes
    input wire dirWe,
    input wire dataWe,
    input wire wrBit,
    // Pad
    input wire padIn,
    output wire padOut,
    output wire padOe,
    // Read-back
    output wire rdDir,
    output wire rdData
);

    reg dir_reg;
    reg data_reg;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_reg <= 1'b0;
            data_reg <= 1'b0;
        end else begin
            if (dirWe) begin
                dir_reg <= wrBit;
            end
            if (dataWe) begin
                data_reg <= wrBit;
            end
        end
    end

    assign padOut = data_reg;
    assign padOe = dir_reg;
    assign rdDir = dir_reg;
    assign rdData = dir_reg ? data_reg : padIn;

endmodule

// ==== tb/ppm_port_pin_mux_assertions.sv ====
// Concurrent checks on the ports of the port pin mux group.
module ppm_port_pin_mux_assertions (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Register port
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdata,
    // Peripheral settings and signals
    input wire [3:0] timerOutSelect,
    input wire rxEnable,
    input wire clockSourceBit1,
    input wire clockSourceBit0,
    input wire clockedMode,
    input wire [7:0] analogChannelMask,
    input wire timerCompareOut,
    input wire timerCountIn,
    input wire timerResetIn,
    input wire serialRxData,
    input wire serialClockOut,
    // Pads
    input wire [7:0] port7PinIn,
    input wire [7:0] port7PinOut,
    input wire [7:0] port7PinOe,
    input wire [7:0] port8PinIn,
    input wire [7:0] port8PinOut,
    input wire [7:0] port8PinOe,
    input wire [7:0] analogPortPins,
    input wire [7:0] analogPortOe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Port 7 sharing
    a_cmp_timer_own: assert property (timerOutSelect != 4'h0 |->
        port7PinOe[6] && port7PinOut[6] == timerCompareOut) else $error("timer pin wrong");
    a_count_feed: assert property (timerCountIn == port7PinIn[5] &&
        timerResetIn == port7PinIn[4]) else $error("timer inputs not fed");
    a_rx_claim: assert property (rxEnable |->
        !port7PinOe[1] && serialRxData == port7PinIn[1]) else $error("receive pin wrong");
    a_clk_input: assert property (clockSourceBit1 |-> !port7PinOe[0])
        else $error("clock pin drives as input");
    a_clk_output: assert property (!clockSourceBit1 && (clockSourceBit0 || clockedMode) |->
        port7PinOe[0] && port7PinOut[0] == serialClockOut) else $error("clock pin not output");
    // ==========================================================
    // Port 8 and port B
    a_p8_dir_write: assert property (regWr && regAddr == 4'h2 |=>
        port8PinOe[7:5] == $past(regWdata[7:5])) else $error("direction write lost");
    a_p8_read_mix: assert property (regRd && regAddr == 4'h3 |=> regRdata ==
        ((($past(port8PinOe) & $past(port8PinOut)) | (~$past(port8PinOe) & $past(port8PinIn)))
        & 8'hE0 | 8'h1F)) else $error("port 8 read wrong");
    a_pb_read: assert property (regRd && regAddr == 4'h4 |=>
        regRdata == ($past(analogPortPins) & ~$past(analogChannelMask))) else $error("pb read");
    a_no_drive: assert property (analogPortOe == 8'h00 && port8PinOe[4:0] == 5'h00)
        else $error("unused pin drives");
endmodule

bind ppm_port_pin_mux ppm_port_pin_mux_assertions ppm_port_pin_mux_assertions_i (.*);

// ==== tb/ppm_board_model.sv ====
// Board-side model of the general-purpose pins.
module ppm_board_model (
    // Board levels
    input wire [7:0] p7Board,
    input wire [7:0] p8Board,
    // Block drivers
    input wire [7:0] port7PinOut,
    input wire [7:0] port7PinOe,
    input wire [7:0] port8PinOut,
    input wire [7:0] port8PinOe,
    // Resolved pins
    output wire [7:0] port7PinIn,
    output wire [7:0] port8PinIn
);
    timeunit 1ns;
    timeprecision 100ps;
    // A released pin falls back to the board level, so stale block values never linger.
    assign port7PinIn = (port7PinOe & port7PinOut) | (~port7PinOe & p7Board);
    assign port8PinIn = (port8PinOe & port8PinOut) | (~port8PinOe & p8Board);
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the port pin mux group.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 0, rst_n = 0, regWr = 0, regRd = 0, rxEnable = 0;
    logic clockSourceBit1 = 0, clockSourceBit0 = 0, clockedMode = 0;
    logic timerCompareOut = 0, serialTxData = 0, serialClockOut = 0;
    logic [3:0] regAddr = 4'h0, timerOutSelect = 4'h0;
    logic [7:0] regWdata = 8'h00, analogChannelMask = 8'h00, analogPortPins = 8'h00;
    logic [7:0] p7Board = 8'h00, p8Board = 8'hA0;
    logic [7:0] regRdata, port7PinIn, port7PinOut, port7PinOe, port8PinIn;
    logic [7:0] port8PinOut, port8PinOe, analogPortOut, analogPortOe;
    logic timerCountIn, timerResetIn, serialRxData, serialClockIn;
    int fails = 0, comparisons = 0, cycles = 0;
    ppm_port_pin_mux ppm_port_pin_mux_i (.*);
    ppm_board_model ppm_board_model_i (.*);
    always #5 ref_clk = ~ref_clk;
    // ==========================================================
    // Shared tasks
    task finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_port8;
        logic [7:0] d;
        rd(4'h3, d);
        chk("p8 reset read", d, 8'hBF);
        chk("p8 reset oe", port8PinOe, 8'h00);
        wr(4'h2, 8'hE0);
        wr(4'h3, 8'h40);
        #1;
        chk("p8 oe", port8PinOe, 8'hE0);
        chk("p8 out", port8PinOut & 8'hE0, 8'h40);
        rd(4'h3, d);
        chk("p8 stored", d, 8'h5F);
        wr(4'h2, 8'h60);
        rd(4'h3, d);
        chk("p8 mixed", d, 8'hDF);
        rd(4'h2, d);
        chk("p8 dir read", d, 8'h00);
        chk("p8 oe input", port8PinOe, 8'h60);
    endtask
    task automatic t_portb;
        logic [7:0] d;
        @(posedge ref_clk);
        analogPortPins <= 8'hA5;
        analogChannelMask <= 8'h0F;
        wr(4'h4, 8'hFF);
        rd(4'h4, d);
        chk("pb read", d, 8'hA0);
        chk("pb oe", analogPortOe, 8'h00);
        chk("pb out", analogPortOut, 8'h00);
    endtask
    task automatic t_port7;
        logic [7:0] d;
        wr(4'h0, 8'h77);
        wr(4'h1, 8'h24);
        #1;
        chk("timer inputs", {6'h00, timerCountIn, timerResetIn}, 8'h02);
        chk("p7 gpio oe", port7PinOe, 8'h77);
        chk("p7 gpio out", port7PinOut & 8'h77, 8'h24);
        rd(4'h1, d);
        chk("p7 read", d, 8'hAC);
        @(posedge ref_clk);
        timerOutSelect <= 4'h9;
        timerCompareOut <= 1'b1;
        rxEnable <= 1'b1;
        clockedMode <= 1'b1;
        serialClockOut <= 1'b1;
        p7Board <= 8'h02;
        #1;
        chk("p7 claim oe", port7PinOe, 8'h75);
        chk("p7 claim out", port7PinOut & port7PinOe, 8'h65);
        chk("rx in", {7'h00, serialRxData}, 8'h01);
        chk("clk in gated", {7'h00, serialClockIn}, 8'h00);
        wr(4'h5, 8'h01);
        @(posedge ref_clk);
        timerOutSelect <= 4'h0;
        clockSourceBit1 <= 1'b1;
        p7Board <= 8'h03;
        #1;
        chk("p7 tx oe", port7PinOe, 8'h74);
        chk("p7 tx out", port7PinOut & port7PinOe, 8'h20);
        chk("clk in", {7'h00, serialClockIn}, 8'h01);
    endtask
    // ==========================================================
    // Main sequence and hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_port8;
        t_portb;
        t_port7;
        finish_test;
    end
endmodule
